/* hw/ltf_sequencer.v */
/*
 LED toggle/fade sequencer: debounces the toggle input, steps the current
 target through a gamma table, and applies short and thermal derating.
 Assumes toggle input, short comparator and die temperature synchronous
 to clk_i; the analog regulator scales current_level_o by its resistor.
*/
`timescale 1ns/100ps
`include "ltf_regs.vh"

module ltf_sequencer #(
    parameter DEBOUNCE_CYC = (`LTF_DEBOUNCE_MS * `LTF_NS_PER_MS) / `LTF_CLK_PERIOD_NS,
    parameter FAULT_CYC = (`LTF_FAULT_PERSIST_MS * `LTF_NS_PER_MS) / `LTF_CLK_PERIOD_NS,
    parameter INSTANT_CYC = `LTF_INSTANT_NS / `LTF_CLK_PERIOD_NS,
    parameter CNT_W = 32,
    parameter RES_W = 20
)
(
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Toggle input, low is pressed; undriven reads high
    input wire toggle_n_i,
    // Fade resistor in ohms; zero means timing pin grounded
    input wire [RES_W-1:0] fade_resistor_i,
    // Output below short detect threshold
    input wire short_detect_i,
    // Die temperature, degrees C, signed
    input wire signed [8:0] die_temp_i,
    // Current target, per-mille of programmed value
    output reg [9:0] current_level_o,
    // Channel state
    output reg sourcing_o,
    output reg ramping_o,
    output reg short_fault_o,
    output reg thermal_off_o
);

// ----------------------------------------
// Gamma table
// ----------------------------------------
// gamma levels
function [9:0] ltf_gamma;
    input [5:0] idx;
    begin
        case (idx)
            6'd0: ltf_gamma = 10'd0;     6'd1: ltf_gamma = 10'd2;
            6'd2: ltf_gamma = 10'd4;     6'd3: ltf_gamma = 10'd6;
            6'd4: ltf_gamma = 10'd8;     6'd5: ltf_gamma = 10'd10;
            6'd6: ltf_gamma = 10'd12;    6'd7: ltf_gamma = 10'd16;
            6'd8: ltf_gamma = 10'd20;    6'd9: ltf_gamma = 10'd24;
            6'd10: ltf_gamma = 10'd28;   6'd11: ltf_gamma = 10'd32;
            6'd12: ltf_gamma = 10'd36;   6'd13: ltf_gamma = 10'd42;
            6'd14: ltf_gamma = 10'd48;   6'd15: ltf_gamma = 10'd54;
            6'd16: ltf_gamma = 10'd60;   6'd17: ltf_gamma = 10'd66;
            6'd18: ltf_gamma = 10'd72;   6'd19: ltf_gamma = 10'd80;
            6'd20: ltf_gamma = 10'd88;   6'd21: ltf_gamma = 10'd96;
            6'd22: ltf_gamma = 10'd104;  6'd23: ltf_gamma = 10'd112;
            6'd24: ltf_gamma = 10'd120;  6'd25: ltf_gamma = 10'd130;
            6'd26: ltf_gamma = 10'd140;  6'd27: ltf_gamma = 10'd150;
            6'd28: ltf_gamma = 10'd160;  6'd29: ltf_gamma = 10'd170;
            6'd30: ltf_gamma = 10'd180;  6'd31: ltf_gamma = 10'd194;
            6'd32: ltf_gamma = 10'd208;  6'd33: ltf_gamma = 10'd222;
            6'd34: ltf_gamma = 10'd236;  6'd35: ltf_gamma = 10'd250;
            6'd36: ltf_gamma = 10'd264;  6'd37: ltf_gamma = 10'd282;
            6'd38: ltf_gamma = 10'd300;  6'd39: ltf_gamma = 10'd318;
            6'd40: ltf_gamma = 10'd336;  6'd41: ltf_gamma = 10'd354;
            6'd42: ltf_gamma = 10'd372;  6'd43: ltf_gamma = 10'd394;
            6'd44: ltf_gamma = 10'd416;  6'd45: ltf_gamma = 10'd438;
            6'd46: ltf_gamma = 10'd460;  6'd47: ltf_gamma = 10'd482;
            6'd48: ltf_gamma = 10'd504;  6'd49: ltf_gamma = 10'd534;
            6'd50: ltf_gamma = 10'd564;  6'd51: ltf_gamma = 10'd594;
            6'd52: ltf_gamma = 10'd624;  6'd53: ltf_gamma = 10'd654;
            6'd54: ltf_gamma = 10'd684;  6'd55: ltf_gamma = 10'd722;
            6'd56: ltf_gamma = 10'd760;  6'd57: ltf_gamma = 10'd798;
            6'd58: ltf_gamma = 10'd836;  6'd59: ltf_gamma = 10'd874;
            6'd60: ltf_gamma = 10'd914;  6'd61: ltf_gamma = 10'd956;
            6'd62: ltf_gamma = 10'd1000;
            default: ltf_gamma = `LTF_FULL_SCALE;
        endcase
    end
endfunction

// ----------------------------------------
// Step interval
// ----------------------------------------
// Resistor widened before the product
wire [CNT_W+11:0] res_ext = {{(CNT_W+12-RES_W){1'b0}}, fade_resistor_i};
wire [CNT_W+11:0] fade_cyc = res_ext * (`LTF_FADE_NS_PER_OHM / `LTF_CLK_PERIOD_NS);
wire [CNT_W+11:0] step_raw = (fade_resistor_i == {RES_W{1'b0}})
    ? INSTANT_CYC / (`LTF_LEVELS - 1)
    : fade_cyc / (`LTF_LEVELS - 1);
wire [CNT_W-1:0] step_cyc = (step_raw == 0) ? 1 : step_raw[CNT_W-1:0];

// ----------------------------------------
// Debounce
// ----------------------------------------
reg deb_state_r;
reg [CNT_W-1:0] deb_cnt_r;
reg press_r;

always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        deb_state_r <= 1'b1;
        deb_cnt_r <= {CNT_W{1'b0}};
        press_r <= 1'b0;
    end
    else
    begin
        press_r <= 1'b0;
        if (toggle_n_i == deb_state_r)
            deb_cnt_r <= {CNT_W{1'b0}};
        else if (deb_cnt_r >= DEBOUNCE_CYC - 1)
        begin
            deb_cnt_r <= {CNT_W{1'b0}};
            deb_state_r <= toggle_n_i;
            press_r <= ~toggle_n_i;
        end
        else
            deb_cnt_r <= deb_cnt_r + 1'b1;
    end
end

// ----------------------------------------
// Short fault filter
// ----------------------------------------
reg [CNT_W-1:0] flt_cnt_r;
reg short_r;

always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        flt_cnt_r <= {CNT_W{1'b0}};
        short_r <= 1'b0;
    end
    else if (!short_detect_i)
    begin
        flt_cnt_r <= {CNT_W{1'b0}};
        short_r <= 1'b0;
    end
    else if (flt_cnt_r >= FAULT_CYC - 1)
        short_r <= 1'b1;
    else
        flt_cnt_r <= flt_cnt_r + 1'b1;
end

// ----------------------------------------
// Thermal state
// ----------------------------------------
reg tsd_r;
always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
        tsd_r <= 1'b0;
    else if (die_temp_i > $signed(`LTF_SHUTDOWN_C))
        tsd_r <= 1'b1;
    else if (die_temp_i < $signed(`LTF_RESTART_C))
        tsd_r <= 1'b0;
end

// ----------------------------------------
// Fade sequencer
// ----------------------------------------
localparam ST_OFF = 2'b00;
localparam ST_UP = 2'b01;
localparam ST_ON = 2'b10;
localparam ST_DOWN = 2'b11;

reg [1:0] state_r;
reg [1:0] state_nxt;
reg [5:0] idx_r;
reg [5:0] idx_nxt;
reg [CNT_W-1:0] tick_cnt_r;
// Step strobe from the timebase counter
wire tick = (tick_cnt_r >= step_cyc - 1);

always @*
begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    case (state_r)
        ST_OFF:
        begin
            if (press_r && !tsd_r)
                state_nxt = ST_UP;
        end
        ST_UP:
        begin
            if (press_r)
                state_nxt = ST_DOWN;
            // Reversed at the top, no step left
            else if (idx_r == `LTF_IDX_MAX)
                state_nxt = ST_ON;
            else if (tick)
            begin
                idx_nxt = idx_r + 6'd1;
                if (idx_r + 6'd1 == `LTF_IDX_MAX)
                    state_nxt = ST_ON;
            end
        end
        ST_ON:
        begin
            if (press_r)
                state_nxt = ST_DOWN;
        end
        ST_DOWN:
        begin
            if (press_r && !tsd_r)
                state_nxt = ST_UP;
            // Reversed at the bottom, no step left
            else if (idx_r == `LTF_IDX_ZERO)
                state_nxt = ST_OFF;
            else if (tick)
            begin
                idx_nxt = idx_r - 6'd1;
                if (idx_r - 6'd1 == `LTF_IDX_ZERO)
                    state_nxt = ST_OFF;
            end
        end
        default:
            state_nxt = ST_OFF;
    endcase
    if (tsd_r)
    begin
        state_nxt = ST_OFF;
        idx_nxt = `LTF_IDX_ZERO;
    end
end

always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        state_r <= ST_OFF;
        idx_r <= `LTF_IDX_ZERO;
        tick_cnt_r <= {CNT_W{1'b0}};
    end
    else
    begin
        state_r <= state_nxt;
        idx_r <= idx_nxt;
        // Timebase restarts on every state change
        if (state_nxt != state_r || tick)
            tick_cnt_r <= {CNT_W{1'b0}};
        else
            tick_cnt_r <= tick_cnt_r + 1'b1;
    end
end

// ----------------------------------------
// Derating and outputs
// ----------------------------------------
reg [9:0] base_lvl;
reg [6:0] pct;
reg [16:0] scaled;
// Percent figures at the width of pct
localparam [6:0] PCT_FULL = `LTF_PCT_FULL;
localparam [6:0] PCT_SHORT = `LTF_SHORT_PCT;
always @*
begin
    base_lvl = ltf_gamma(idx_nxt);
    pct = PCT_FULL;
    if (die_temp_i > $signed(`LTF_ROLLOFF_C))
    begin
        if (die_temp_i - $signed(`LTF_ROLLOFF_C) >= 9'sd33)
            pct = 7'd1;
        else
            pct = 7'd100 - (die_temp_i[6:0] - 7'd2) * 7'd3;
    end
    if (short_r && pct > PCT_SHORT)
        pct = PCT_SHORT;
    scaled = ({7'd0, base_lvl} * {10'd0, pct}) / {10'd0, PCT_FULL};
end

// Registered outputs, level from next index
always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        current_level_o <= 10'h000;
        sourcing_o <= 1'b0;
        ramping_o <= 1'b0;
        short_fault_o <= 1'b0;
        thermal_off_o <= 1'b0;
    end
    else
    begin
        current_level_o <= scaled[9:0];
        sourcing_o <= (state_nxt == ST_UP) || (state_nxt == ST_ON);
        ramping_o <= (state_nxt == ST_UP) || (state_nxt == ST_DOWN);
        short_fault_o <= short_r;
        thermal_off_o <= tsd_r;
    end
end

endmodule

/* shared/ltf_regs.vh */
/*
 Constants for the LED toggle/fade sequencer: timing figures, table size,
 fault scaling and thermal thresholds.
 Assumes a 100 MHz system clock; header holds definitions only.
*/
`ifndef LTF_REGS_VH
`define LTF_REGS_VH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define LTF_CLK_MHZ 100
`define LTF_DEBOUNCE_MS 37
`define LTF_FAULT_PERSIST_MS 5
`define LTF_FADE_NS_PER_OHM 2500
`define LTF_INSTANT_NS 73000
`define LTF_NS_PER_MS 1000000
`define LTF_CLK_PERIOD_NS 10

// ----------------------------------------
// Level table
// ----------------------------------------
`define LTF_LEVELS 63
`define LTF_IDX_MAX 6'h3E
`define LTF_IDX_ZERO 6'h00
`define LTF_FULL_SCALE 10'h3E8

// ----------------------------------------
// Fault and thermal
// ----------------------------------------
`define LTF_SHORT_PCT 20
`define LTF_ROLLOFF_C 130
`define LTF_SHUTDOWN_C 155
`define LTF_RESTART_C 135
`define LTF_ROLLOFF_PCT_PER_C 3
`define LTF_PCT_FULL 100

`endif

/* verif/ltf_props.sv */
/*
 Port checker for ltf_sequencer, bound to every instance.
 Assumes toggle, short and temperature inputs synchronous to clk_i.
*/
`timescale 1ns/100ps
module ltf_props #(
    parameter DEBOUNCE_CYC = 20,
    parameter FAULT_CYC = 10,
    parameter RES_W = 20
)
(
    // Inputs
    input wire clk_i,
    input wire rst_i,
    input wire toggle_n_i,
    input wire [RES_W-1:0] fade_resistor_i,
    input wire short_detect_i,
    input wire signed [8:0] die_temp_i,
    // Outputs
    input wire [9:0] current_level_o,
    input wire sourcing_o,
    input wire ramping_o,
    input wire short_fault_o,
    input wire thermal_off_o
);
    // ----------------------------------------
    // Helper counters
    // ----------------------------------------
    reg [31:0] low_r;
    reg [31:0] shrt_r;
    wire signed [15:0] roll_w = (16'sd100 - 16'sd3 * (die_temp_i - 9'sd130)) * 16'sd10;
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            low_r <= 32'h0;
            shrt_r <= 32'h0;
        end
        else
        begin
            low_r <= toggle_n_i ? 32'h0 : low_r + 32'h1;
            shrt_r <= short_detect_i ? shrt_r + 32'h1 : 32'h0;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_reset_off;
        $fell(rst_i) |-> !sourcing_o && current_level_o == 10'h0;
    endproperty
    a_reset_off: assert property (p_reset_off) else $error("channel not off after reset");
    property p_press_qual;
        $changed(sourcing_o) |-> die_temp_i > 155 || thermal_off_o
            || (low_r >= DEBOUNCE_CYC && low_r <= DEBOUNCE_CYC + 4);
    endproperty
    a_press_qual: assert property (p_press_qual) else $error("toggle without debounce");
    property p_instant;
        $rose(ramping_o) && fade_resistor_i == 0 |-> ##55 ramping_o ##[1:15] !ramping_o;
    endproperty
    a_instant: assert property (p_instant) else $error("instant ramp length wrong");
    property p_full_on;
        sourcing_o && !ramping_o && !short_fault_o && !$past(short_fault_o) && die_temp_i <= 130
            && $stable(die_temp_i) |-> current_level_o == 10'h3E8;
    endproperty
    a_full_on: assert property (p_full_on) else $error("full level not reached");
    property p_off_zero;
        !sourcing_o && !ramping_o |-> current_level_o == 10'h0;
    endproperty
    a_off_zero: assert property (p_off_zero) else $error("current while off");
    property p_short_set;
        $rose(short_fault_o) |-> shrt_r >= FAULT_CYC && shrt_r <= FAULT_CYC + 3;
    endproperty
    a_short_set: assert property (p_short_set) else $error("short filter length wrong");
    property p_short_clear;
        $fell(short_detect_i) |-> ##[1:3] !short_fault_o;
    endproperty
    a_short_clear: assert property (p_short_clear) else $error("short fault stuck");
    property p_short_lvl;
        short_fault_o && $past(short_fault_o) |-> current_level_o <= 10'h0C8;
    endproperty
    a_short_lvl: assert property (p_short_lvl) else $error("short level above limit");
    property p_tsd;
        die_temp_i > 155 |-> ##[1:3] thermal_off_o && !sourcing_o;
    endproperty
    a_tsd: assert property (p_tsd) else $error("no thermal shutdown");
    property p_lock;
        thermal_off_o && die_temp_i >= 135 |=> thermal_off_o && !sourcing_o;
    endproperty
    a_lock: assert property (p_lock) else $error("lockout released early");
    property p_roll;
        sourcing_o && !ramping_o && !short_fault_o && die_temp_i > 130 && die_temp_i <= 155
            && $stable(die_temp_i) |-> current_level_o == roll_w[9:0];
    endproperty
    a_roll: assert property (p_roll) else $error("rolloff level wrong");
endmodule

bind ltf_sequencer ltf_props #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .FAULT_CYC(FAULT_CYC), .RES_W(RES_W)) ltf_props_inst (
    .clk_i(clk_i), .rst_i(rst_i), .toggle_n_i(toggle_n_i), .fade_resistor_i(fade_resistor_i),
    .short_detect_i(short_detect_i), .die_temp_i(die_temp_i), .current_level_o(current_level_o),
    .sourcing_o(sourcing_o), .ramping_o(ramping_o), .short_fault_o(short_fault_o),
    .thermal_off_o(thermal_off_o));

/* verif/ltf_switch_model.sv */
/*
 Momentary switch on the toggle input, with contact bounce.
 Steps on the falling clock edge; an open contact reads high.
*/
`timescale 1ns/100ps
module ltf_switch_model #(
    parameter HOLD_CYC = 28
)
(
    // Clock
    input wire clk_i,
    // Contact, low when closed
    output reg toggle_n_o
);
    initial toggle_n_o = 1'b1;
    // ----------------------------------------
    // Bounce, then settle and hold
    // ----------------------------------------
    task automatic settle(input logic lvl);
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1)
            begin
                toggle_n_o = i[0] ? !lvl : lvl;
                repeat (3) @(negedge clk_i);
            end
            toggle_n_o = lvl;
            repeat (HOLD_CYC) @(negedge clk_i);
        end
    endtask
endmodule

/* verif/testbench.sv */
/*
 Self-checking bench for ltf_sequencer driven by a switch model.
 Uses shortened debounce, fault and instant counts.
*/
`timescale 1ns/100ps
module testbench;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg [19:0] fade_resistor_i = 20'h0_0000;
    reg short_detect_i = 1'b0;
    reg signed [8:0] die_temp_i = 9'sh019;
    wire toggle_n_i;
    wire [9:0] current_level_o;
    wire sourcing_o;
    wire ramping_o;
    wire short_fault_o;
    wire thermal_off_o;
    integer n_fail = 0;
    integer n_checks = 0;
    integer cyc = 0;
    integer i;
    always #5 clk_i = ~clk_i;
    ltf_sequencer #(.DEBOUNCE_CYC(20), .FAULT_CYC(10), .INSTANT_CYC(62)) ltf_sequencer_inst (
        .clk_i(clk_i), .rst_i(rst_i), .toggle_n_i(toggle_n_i), .fade_resistor_i(fade_resistor_i),
        .short_detect_i(short_detect_i), .die_temp_i(die_temp_i), .current_level_o(current_level_o),
        .sourcing_o(sourcing_o), .ramping_o(ramping_o), .short_fault_o(short_fault_o),
        .thermal_off_o(thermal_off_o));
    ltf_switch_model ltf_switch_model_inst (.clk_i(clk_i), .toggle_n_o(toggle_n_i));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task chk(input string name, input logic [9:0] exp, input logic [9:0] got);
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            n_fail = n_fail + 1;
            $display("MISMATCH %s expected %0d seen %0d", name, exp, got);
        end
    endtask
    task chk_flag(input string name, input logic exp, input logic got);
        chk(name, {9'h000, exp}, {9'h000, got});
    endtask
    task idle(input integer n);
        repeat (n) @(negedge clk_i);
    endtask
    task wait_ramp;
        for (i = 0; i < 400 && ramping_o === 1'b1; i = i + 1) @(negedge clk_i);
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", n_checks, n_fail);
            if (n_fail == 0 && n_checks > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_on_instant;
        fade_resistor_i = 20'h0_0000;
        ltf_switch_model_inst.settle(1'b0);
        chk_flag("sourcing", 1'b1, sourcing_o);
        chk_flag("ramping", 1'b1, ramping_o);
        wait_ramp;
        chk_flag("ramp_done", 1'b0, ramping_o);
        chk("level", 10'h3E8, current_level_o);
        ltf_switch_model_inst.settle(1'b1);
        chk_flag("held", 1'b1, sourcing_o);
    endtask
    task t_fade_time;
        fade_resistor_i = 20'h0_0001;
        ltf_switch_model_inst.settle(1'b0);
        chk_flag("fading_out", 1'b0, sourcing_o);
        wait_ramp;
        chk_flag("fade_len", 1'b1, i >= 238 && i <= 248);
        chk("off_level", 10'h000, current_level_o);
        ltf_switch_model_inst.settle(1'b1);
    endtask
    task t_reverse;
        ltf_switch_model_inst.settle(1'b0);
        ltf_switch_model_inst.settle(1'b1);
        ltf_switch_model_inst.settle(1'b0);
        chk_flag("reversed", 1'b0, sourcing_o);
        chk_flag("mid", 1'b1, current_level_o > 0 && current_level_o < 10'h3E8);
        wait_ramp;
        chk("rev_end", 10'h000, current_level_o);
        ltf_switch_model_inst.settle(1'b1);
    endtask
    task t_short;
        t_on_instant;
        short_detect_i = 1'b1;
        idle(5);
        short_detect_i = 1'b0;
        idle(3);
        chk_flag("glitch", 1'b0, short_fault_o);
        short_detect_i = 1'b1;
        idle(16);
        chk_flag("fault", 1'b1, short_fault_o);
        chk("short_level", 10'h0C8, current_level_o);
        short_detect_i = 1'b0;
        idle(3);
        chk("restored", 10'h3E8, current_level_o);
    endtask
    task t_thermal;
        die_temp_i = 9'sh08C;
        idle(3);
        chk("rolloff", 10'h2BC, current_level_o);
        die_temp_i = 9'sh0A0;
        idle(3);
        chk_flag("tsd", 1'b1, thermal_off_o);
        chk_flag("tsd_src", 1'b0, sourcing_o);
        die_temp_i = 9'sh08C;
        ltf_switch_model_inst.settle(1'b0);
        chk_flag("blocked", 1'b0, sourcing_o);
        ltf_switch_model_inst.settle(1'b1);
        die_temp_i = 9'sh019;
        idle(3);
        chk_flag("cooled", 1'b0, thermal_off_o);
        t_on_instant;
    endtask
    // ----------------------------------------
    // Main sequence and timeout
    // ----------------------------------------
    initial
    begin
        idle(12);
        rst_i = 1'b0;
        idle(1);
        chk("reset_level", 10'h000, current_level_o);
        chk_flag("reset_src", 1'b0, sourcing_o);
        t_on_instant;
        t_fade_time;
        t_reverse;
        t_short;
        t_thermal;
        finish_test;
    end
    always @(posedge clk_i)
    begin
        cyc = cyc + 1;
        if (cyc == 6000)
        begin
            n_fail = n_fail + 1;
            finish_test;
        end
    end
endmodule
